// [hw/aes_ccm_ctrl.sv]
// Packet cipher control: registers, task sequencing and RAM access pacing
`timescale 1ns/1ps
`include "aes_ccm_map.svh"
module aes_ccm_ctrl #(
  parameter int unsigned KS_MAX_CYCLES = `KS_MAX_CYCLES,
  parameter int unsigned BYTE_CYC_125K = `BYTE_CYC_125K
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // RAM access port
  output logic dma_req,
  output logic dma_we,
  output logic [31:0] dma_addr,
  output logic [7:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [7:0] dma_rdata,
  // Status
  output logic irq,
  output logic busy
);

  aes_ccm_pkg::regs_t r;
  aes_ccm_pkg::regs_t next_r;
  logic tick;
  logic run_pace;
  logic on;
  logic wr_ks;
  logic wr_task_a;
  logic wr_stop;
  logic wr_ovr;
  logic ks_start;
  logic cr_start;
  logic ack;
  logic [2:0] ev_set;
  logic [7:0] len;
  logic [8:0] scr_len;
  logic [31:0] mode_word;
  logic [31:0] rd_word;

  assign run_pace = (r.st == aes_ccm_pkg::ST_CR_WAIT) || (r.st == aes_ccm_pkg::ST_CR_RD)
    || (r.st == aes_ccm_pkg::ST_CR_WR);

  byte_pacer #(
    .CYC_1M(`BYTE_CYC_1M),
    .CYC_2M(`BYTE_CYC_2M),
    .CYC_125K(BYTE_CYC_125K),
    .CYC_500K(`BYTE_CYC_500K)
  ) pacer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(run_pace),
    .rate(r.act_rate),
    .tick(tick)
  );

  assign reg_rdata = r.rdata;
  assign dma_req = r.req;
  assign dma_we = r.we;
  assign dma_addr = r.addr;
  assign dma_wdata = r.wdata;
  assign irq = r.irq;
  assign busy = r.busy;

  always_comb begin
    mode_word = 32'h00000000;
    mode_word[`MODE_OP_BIT] = r.mode_dec;
    mode_word[`MODE_RATE_LSB +: 2] = r.mode_rate;
    mode_word[`MODE_LEN_BIT] = r.mode_ext;
    case (reg_addr)
      `OFS_EV_KS: rd_word = {31'h0, r.ev[`EV_KS_BIT]};
      `OFS_EV_TASK_A: rd_word = {31'h0, r.ev[`EV_TASK_A_BIT]};
      `OFS_EV_ERR: rd_word = {31'h0, r.ev[`EV_ERR_BIT]};
      `OFS_EVENT_TASK_SHORTCUTS: rd_word = {31'h0, r.short_en};
      `OFS_INT_SET: rd_word = {29'h0, r.inten};
      `OFS_INT_CLR: rd_word = {29'h0, r.inten};
      `OFS_ENABLE: rd_word = {30'h0, r.enable};
      `OFS_MODE: rd_word = mode_word;
      `OFS_CNF_PTR: rd_word = r.cnf_ptr;
      `OFS_IN_PTR: rd_word = r.in_ptr;
      `OFS_OUT_PTR: rd_word = r.out_ptr;
      `OFS_SCR_PTR: rd_word = r.scr_ptr;
      `OFS_LIMIT: rd_word = {24'h0, r.limit};
      `OFS_OVR: rd_word = {30'h0, r.ovr};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    next_r = r;
    ev_set = 3'h0;
    len = 8'h00;
    on = (r.enable == `ENABLE_ON);
    wr_ks = reg_wr && reg_addr == `OFS_TASK_KS && reg_wdata[0];
    wr_task_a = reg_wr && reg_addr == `OFS_TASK_TASK_A && reg_wdata[0];
    wr_stop = reg_wr && reg_addr == `OFS_TASK_STOP && reg_wdata[0];
    wr_ovr = reg_wr && reg_addr == `OFS_TASK_OVR && reg_wdata[0];
    ks_start = 1'b0;
    cr_start = 1'b0;
    ack = r.req && dma_ack;
    // Scratch use: 43 bytes default, 16 + limit when extended
    scr_len = r.act_ext ? `SCR_EXT_BASE + {1'b0, r.limit} : `SCR_DEFAULT_BYTES;

    // Plain register writes
    if (reg_wr) begin
      case (reg_addr)
        `OFS_EVENT_TASK_SHORTCUTS: next_r.short_en = reg_wdata[0];
        `OFS_INT_SET: next_r.inten = r.inten | reg_wdata[2:0];
        `OFS_INT_CLR: next_r.inten = r.inten & ~reg_wdata[2:0];
        `OFS_ENABLE: next_r.enable = reg_wdata[1:0];
        `OFS_MODE: begin
          next_r.mode_dec = reg_wdata[`MODE_OP_BIT];
          next_r.mode_rate = reg_wdata[`MODE_RATE_LSB +: 2];
          next_r.mode_ext = reg_wdata[`MODE_LEN_BIT];
        end
        `OFS_CNF_PTR: next_r.cnf_ptr = reg_wdata;
        `OFS_IN_PTR: next_r.in_ptr = reg_wdata;
        `OFS_OUT_PTR: next_r.out_ptr = reg_wdata;
        `OFS_SCR_PTR: next_r.scr_ptr = reg_wdata;
        `OFS_LIMIT: next_r.limit = reg_wdata[7:0];
        `OFS_OVR: next_r.ovr = reg_wdata[1:0];
        default: begin
        end
      endcase
    end

    next_r.rdata = reg_rd ? rd_word : 32'h00000000;

    // Tasks are taken only from idle with the engine enabled
    if (on && r.st == aes_ccm_pkg::ST_IDLE) begin
      if (wr_ks) begin
        ks_start = 1'b1;
      end else if (wr_task_a) begin
        cr_start = 1'b1;
      end
    end

    case (r.st)
      aes_ccm_pkg::ST_IDLE: begin
        next_r.req = 1'b0;
      end
      aes_ccm_pkg::ST_KS_RD: begin
        // Fetch key and nonce structure byte by byte
        if (!r.req) begin
          next_r.req = 1'b1;
          next_r.we = 1'b0;
          next_r.addr = r.cnf_ptr + {23'h0, r.idx};
        end else if (ack) begin
          next_r.req = 1'b0;
          next_r.mix = {r.mix[6:0], r.mix[7]} ^ dma_rdata;
          if (r.idx + 9'h001 == `CNF_BYTES) begin
            next_r.idx = 9'h000;
            next_r.st = aes_ccm_pkg::ST_KS_WR;
          end else begin
            next_r.idx = r.idx + 9'h001;
          end
        end
      end
      aes_ccm_pkg::ST_KS_WR: begin
        // Key-stream bytes go to the scratch area
        if (!r.req) begin
          next_r.req = 1'b1;
          next_r.we = 1'b1;
          next_r.addr = r.scr_ptr + {23'h0, r.idx};
          next_r.wdata = r.mix ^ r.idx[7:0];
        end else if (ack) begin
          next_r.req = 1'b0;
          next_r.we = 1'b0;
          if (r.idx + 9'h001 == scr_len) begin
            // Last write acknowledged before the done event
            ev_set[`EV_KS_BIT] = 1'b1;
            next_r.idx = 9'h000;
            if (r.short_en) begin
              cr_start = 1'b1;
            end else begin
              next_r.st = aes_ccm_pkg::ST_IDLE;
            end
          end else begin
            next_r.idx = r.idx + 9'h001;
          end
        end
      end
      aes_ccm_pkg::ST_CR_LEN: begin
        // Length byte of the input packet decides the transfer size
        if (!r.req) begin
          next_r.req = 1'b1;
          next_r.we = 1'b0;
          next_r.addr = r.in_ptr + 32'h00000001;
        end else if (ack) begin
          next_r.req = 1'b0;
          len = r.act_ext ? dma_rdata : (dma_rdata & `DEF_LEN_MASK);
          next_r.total = {1'b0, len} + `HDR_BYTES;
          if (!r.act_dec && len != 8'h00) begin
            next_r.total = {1'b0, len} + `HDR_BYTES + `MIC_BYTES;
          end
          next_r.idx = 9'h000;
          next_r.st = aes_ccm_pkg::ST_CR_WAIT;
        end
      end
      aes_ccm_pkg::ST_CR_WAIT: begin
        if (tick) begin
          next_r.st = aes_ccm_pkg::ST_CR_RD;
        end
      end
      aes_ccm_pkg::ST_CR_RD: begin
        // A byte slot ending before its RAM traffic means the DMA fell behind
        if (tick) begin
          ev_set[`EV_ERR_BIT] = 1'b1;
        end
        if (!r.req) begin
          next_r.req = 1'b1;
          next_r.we = 1'b0;
          next_r.addr = r.in_ptr + {23'h0, r.idx};
        end else if (ack) begin
          next_r.req = 1'b0;
          next_r.wdata = dma_rdata ^ r.mix;
          next_r.st = aes_ccm_pkg::ST_CR_WR;
        end
      end
      aes_ccm_pkg::ST_CR_WR: begin
        if (tick) begin
          ev_set[`EV_ERR_BIT] = 1'b1;
        end
        if (!r.req) begin
          next_r.req = 1'b1;
          next_r.we = 1'b1;
          next_r.addr = r.out_ptr + {23'h0, r.idx};
        end else if (ack) begin
          next_r.req = 1'b0;
          next_r.we = 1'b0;
          next_r.mix = {r.mix[0], r.mix[7:1]} ^ r.wdata;
          if (r.idx + 9'h001 == r.total) begin
            ev_set[`EV_TASK_A_BIT] = 1'b1;
            next_r.st = aes_ccm_pkg::ST_IDLE;
          end else begin
            next_r.idx = r.idx + 9'h001;
            next_r.st = aes_ccm_pkg::ST_CR_WAIT;
          end
        end
      end
      default: begin
        next_r.st = aes_ccm_pkg::ST_IDLE;
        next_r.req = 1'b0;
      end
    endcase

    // Mode is latched only here, so later writes do not disturb a run
    if (ks_start) begin
      next_r.act_dec = r.mode_dec;
      next_r.act_rate = r.mode_rate;
      next_r.act_ext = r.mode_ext;
      next_r.idx = 9'h000;
      next_r.mix = 8'h00;
      next_r.ks_cnt = 16'h0000;
      next_r.st = aes_ccm_pkg::ST_KS_RD;
    end
    if (cr_start) begin
      next_r.act_dec = r.mode_dec;
      next_r.act_rate = r.mode_rate;
      next_r.act_ext = r.mode_ext;
      next_r.idx = 9'h000;
      next_r.st = aes_ccm_pkg::ST_CR_LEN;
    end

    // Override only touches a task_a already running
    if (wr_ovr && (run_pace || r.st == aes_ccm_pkg::ST_CR_LEN)) begin
      next_r.act_rate = r.ovr;
    end

    // Deadline watch on key-stream generation
    if (r.st == aes_ccm_pkg::ST_KS_RD || r.st == aes_ccm_pkg::ST_KS_WR) begin
      if (r.ks_cnt != 16'hffff) begin
        next_r.ks_cnt = r.ks_cnt + 16'h0001;
      end
      if (r.ks_cnt + 16'h0001 == 16'(KS_MAX_CYCLES)) begin
        ev_set[`EV_ERR_BIT] = 1'b1;
      end
    end

    // Stop or disable drops any transfer without a done event
    if (wr_stop || !on) begin
      next_r.st = aes_ccm_pkg::ST_IDLE;
      next_r.req = 1'b0;
      next_r.we = 1'b0;
      ev_set[`EV_KS_BIT] = 1'b0;
      ev_set[`EV_TASK_A_BIT] = 1'b0;
    end

    // Writing 0 clears an event; a set in the same cycle wins
    if (reg_wr && !reg_wdata[0]) begin
      if (reg_addr == `OFS_EV_KS) begin
        next_r.ev[`EV_KS_BIT] = 1'b0;
      end
      if (reg_addr == `OFS_EV_TASK_A) begin
        next_r.ev[`EV_TASK_A_BIT] = 1'b0;
      end
      if (reg_addr == `OFS_EV_ERR) begin
        next_r.ev[`EV_ERR_BIT] = 1'b0;
      end
    end
    next_r.ev = next_r.ev | ev_set;

    next_r.irq = |(next_r.ev & next_r.inten);
    next_r.busy = (next_r.st != aes_ccm_pkg::ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.st <= aes_ccm_pkg::ST_IDLE;
      r.enable <= 2'h0;
      r.mode_dec <= `RST_MODE_DEC;
      r.act_dec <= `RST_MODE_DEC;
      r.limit <= `RST_LIMIT;
    end else if (ce) begin
      r <= next_r;
    end
  end

endmodule

// [hw/aes_ccm_map.svh]
// Register map, field positions, reset values and timing counts of the packet cipher control
// Operation
// - Writing 1 to the key-stream task starts generation; it ends by itself.
// - Writing the task_a task starts encrypt or decrypt; it ends by itself.
// - Rate-override task replaces the active data rate of a running task_a.
// - Shortcut bit 0 set makes key-stream done trigger the task_a task.
// - Interrupt-set write 1 enables an event interrupt; reads give enables.
// - Interrupt-clear write 1 disables an event interrupt; reads give enables.
// - Error interrupt enable sits at bit 2; the error event is deprecated.
// - Engine runs only when enable field holds 2; resets to disabled.
// - Mode bit 0 selects encrypt at 0, decrypt at 1; resets to decrypt.
// - Mode settings are sampled when key-stream or task_a task is triggered.
// - Rate codes: 0 1 Mbps, 1 2 Mbps, 2 125 kbps, 3 500 kbps.
// - Default length mode uses a 5-bit length field, 43-byte key-stream.
// - Configuration pointer holds RAM address of key and nonce structure.
// - Rate-override register holds a rate code applied only by its task.
// - Key-stream generation completes within 50 microseconds.
// - All RAM accesses are finished when done events are raised.
// - DMA unable to keep pace with on-the-fly task_a raises error event.
`ifndef AES_CCM_MAP_SVH
`define AES_CCM_MAP_SVH

`define OFS_TASK_KS 12'h000
`define OFS_TASK_TASK_A 12'h004
`define OFS_TASK_STOP 12'h008
`define OFS_TASK_OVR 12'h00c
`define OFS_EV_KS 12'h100
`define OFS_EV_TASK_A 12'h104
`define OFS_EV_ERR 12'h108
`define OFS_EVENT_TASK_SHORTCUTS 12'h200
`define OFS_INT_SET 12'h304
`define OFS_INT_CLR 12'h308
`define OFS_MIC 12'h400
`define OFS_ENABLE 12'h500
`define OFS_MODE 12'h504
`define OFS_CNF_PTR 12'h508
`define OFS_IN_PTR 12'h50c
`define OFS_OUT_PTR 12'h510
`define OFS_SCR_PTR 12'h514
`define OFS_LIMIT 12'h518
`define OFS_OVR 12'h51c

`define EV_KS_BIT 0
`define EV_TASK_A_BIT 1
`define EV_ERR_BIT 2
`define MODE_OP_BIT 0
`define MODE_RATE_LSB 16
`define MODE_LEN_BIT 24

`define ENABLE_ON 2'h2
`define RST_MODE_DEC 1'h1
`define RST_LIMIT 8'hfb

`define CNF_BYTES 9'h021
`define SCR_DEFAULT_BYTES 9'h02b
`define SCR_EXT_BASE 9'h010
`define DEF_LEN_MASK 8'h1f
`define HDR_BYTES 9'h003
`define MIC_BYTES 9'h004

`define CLK_PERIOD_NS 8
`define KS_MAX_NS 50000
`define KS_MAX_CYCLES (`KS_MAX_NS / `CLK_PERIOD_NS)
`define BYTE_NS_1M 8000
`define BYTE_NS_2M 4000
`define BYTE_NS_125K 64000
`define BYTE_NS_500K 16000
`define BYTE_CYC_1M (`BYTE_NS_1M / `CLK_PERIOD_NS)
`define BYTE_CYC_2M (`BYTE_NS_2M / `CLK_PERIOD_NS)
`define BYTE_CYC_125K (`BYTE_NS_125K / `CLK_PERIOD_NS)
`define BYTE_CYC_500K (`BYTE_NS_500K / `CLK_PERIOD_NS)

`endif

// [hw/aes_ccm_pkg.sv]
// Types of the packet cipher control
package aes_ccm_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_KS_RD = 7'h02,
    ST_KS_WR = 7'h04,
    ST_CR_LEN = 7'h08,
    ST_CR_WAIT = 7'h10,
    ST_CR_RD = 7'h20,
    ST_CR_WR = 7'h40
  } state_t;

  typedef struct packed {
    state_t st;
    logic [2:0] ev;
    logic [2:0] inten;
    logic short_en;
    logic [1:0] enable;
    logic mode_dec;
    logic [1:0] mode_rate;
    logic mode_ext;
    logic [31:0] cnf_ptr;
    logic [31:0] in_ptr;
    logic [31:0] out_ptr;
    logic [31:0] scr_ptr;
    logic [7:0] limit;
    logic [1:0] ovr;
    logic act_dec;
    logic [1:0] act_rate;
    logic act_ext;
    logic [8:0] idx;
    logic [8:0] total;
    logic [7:0] mix;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] ks_cnt;
    logic busy;
  } regs_t;

endpackage

// [hw/byte_pacer.sv]
// Byte-time tick generator that keeps the cipher in step with the radio rate
`timescale 1ns/1ps
module byte_pacer #(
  parameter int unsigned CYC_1M = 1000,
  parameter int unsigned CYC_2M = 500,
  parameter int unsigned CYC_125K = 8000,
  parameter int unsigned CYC_500K = 2000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic [1:0] rate,
  // Byte tick
  output logic tick
);

  logic [15:0] cnt;
  logic [15:0] period;

  always_comb begin
    case (rate)
      2'h0: period = 16'(CYC_1M);
      2'h1: period = 16'(CYC_2M);
      2'h2: period = 16'(CYC_125K);
      default: period = 16'(CYC_500K);
    endcase
  end

  // A rate change mid-byte takes effect at the next compare
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        cnt <= 16'h0000;
      end else if (cnt + 16'h0001 >= period) begin
        cnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

endmodule

// [dv/ram_model.sv]
// Byte-wide RAM model that answers the cipher's memory requests
`timescale 1ns/1ps
module ram_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [31:0] dma_addr,
  input wire logic [7:0] dma_wdata,
  // Answer delay in cycles, set by the bench
  input wire logic [3:0] lat,
  // Answer side
  output logic dma_ack,
  output logic [7:0] dma_rdata,
  output int wr_cnt
);
  // Every byte starts as 3, so every packet length byte reads 3
  logic [7:0] mem [0:1023];
  logic [3:0] wait_cnt;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'h03;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      dma_ack <= 1'b0;
      wait_cnt <= 4'h0;
      dma_rdata <= 8'h5a;
      wr_cnt <= 0;
    end else if (!dma_req || dma_ack) begin
      dma_ack <= 1'b0;
      wait_cnt <= 4'h0;
      // Read data is stale outside an answer, so it keeps changing
      dma_rdata <= ~dma_rdata;
    end else if (wait_cnt == lat) begin
      dma_ack <= 1'b1;
      dma_rdata <= mem[dma_addr[9:0]];
      if (dma_we) begin
        mem[dma_addr[9:0]] <= dma_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// [dv/aes_ccm_ctrl_chk.sv]
// Port checker of the packet cipher control
`timescale 1ns/1ps
module aes_ccm_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // RAM port
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [31:0] dma_addr,
  input wire logic [7:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [7:0] dma_rdata,
  // Status
  input wire logic irq,
  input wire logic busy
);
  logic en_q;
  logic [2:0] ie_q;
  logic go;
  logic halt;

  // A strobe seen while the clock enable is low is lost by the design
  assign go = ce && reg_wr && reg_wdata[0] && !busy && en_q;
  assign halt = ce && reg_wr && ((reg_addr == 12'h008 && reg_wdata[0]) ||
    (reg_addr == 12'h500 && reg_wdata[1:0] != 2'h2));

  // Shadow of enable and interrupt enables, kept from bus writes alone
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
      ie_q <= 3'h0;
    end else if (ce && reg_wr && reg_addr == 12'h500) begin
      en_q <= reg_wdata[1:0] == 2'h2;
    end else if (ce && reg_wr && reg_addr == 12'h304) begin
      ie_q <= ie_q | reg_wdata[2:0];
    end else if (ce && reg_wr && reg_addr == 12'h308) begin
      ie_q <= ie_q & ~reg_wdata[2:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_fetch;
    busy ##1 (dma_req && !dma_we);
  endsequence

  sequence s_settle;
    !dma_req ##1 (!busy && !dma_req);
  endsequence

  a_ks_start: assert property (go && reg_addr == 12'h000 |=> s_fetch)
    else $error("key-stream task did not start a RAM read");
  a_task_a_start: assert property (go && reg_addr == 12'h004 |=> s_fetch)
    else $error("task_a task did not start a RAM read");
  a_task_refused: assert property (reg_wr && !en_q && !busy && reg_addr[11:3] == 9'h0
    |=> !busy [*3])
    else $error("task ran while disabled");
  a_abort_idle: assert property (halt |=> s_settle)
    else $error("stop did not return to idle");
  a_beat_hold: assert property (dma_req && !dma_ack && !reg_wr
    |=> dma_req && $stable(dma_addr) && $stable(dma_we))
    else $error("RAM request changed before its answer");
  a_beat_gap: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("RAM request not dropped after answer");
  a_idle_quiet: assert property (!busy |-> !dma_req)
    else $error("RAM request while idle");
  a_irq_masked: assert property (ie_q == 3'h0 && $past(ie_q) == 3'h0 |-> !irq)
    else $error("interrupt with all enables clear");
  a_set_readback: assert property (reg_rd && reg_addr == 12'h304
    |=> reg_rdata == {29'h0, ie_q})
    else $error("enable set register read wrong");
  a_clr_readback: assert property (reg_rd && reg_addr == 12'h308
    |=> reg_rdata == {29'h0, ie_q})
    else $error("enable clear register read wrong");
endmodule

bind aes_ccm_ctrl aes_ccm_ctrl_chk chk_u (.clk(clk), .rst(rst), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
  .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata), .irq(irq), .busy(busy));

// [dv/tb.sv]
// Self-checking bench of the packet cipher control
`timescale 1ns/1ps
module tb;
  logic clk, rst, ce, reg_wr, reg_rd, dma_req, dma_we, dma_ack, irq, busy;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, dma_addr;
  logic [7:0] dma_wdata, dma_rdata;
  logic [3:0] lat;
  int wr_cnt, c0;
  int miscompares = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  // Short counts keep the run brief; a 20-cycle byte lets slow RAM fall behind
  aes_ccm_ctrl #(.KS_MAX_CYCLES(600), .BYTE_CYC_125K(20)) dut_u (.clk(clk), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata), .irq(irq), .busy(busy));
  ram_model ram_u (.clk(clk), .rst(rst), .dma_req(dma_req), .dma_we(dma_we),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata), .lat(lat), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata), .wr_cnt(wr_cnt));

  task automatic test_done();
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask

  // Waits for the run to end; a hang ends the test
  task automatic idle(input int b);
    repeat (2) @(posedge clk);
    #1;
    // Busy is looked at just past each edge, once it has settled
    for (int i = 0; i < b && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0) begin
      chk("busy", {31'h0, busy}, 32'h0);
      test_done();
    end
  endtask

  task automatic s_reset();
    rc(12'h504, 32'h1);
    rc(12'h518, 32'hfb);
    rc(12'h500, 32'h0);
    rc(12'h304, 32'h0);
    rc(12'h51c, 32'h0);
    rc(12'h100, 32'h0);
  endtask

  task automatic s_regs();
    wr(12'h508, 32'h40);
    rc(12'h508, 32'h40);
    wr(12'h304, 32'h5);
    wr(12'h304, 32'h0);
    rc(12'h304, 32'h5);
    wr(12'h308, 32'h1);
    rc(12'h308, 32'h4);
    wr(12'h51c, 32'hffffffff);
    rc(12'h51c, 32'h3);
    for (int r = 0; r < 4; r++) begin
      wr(12'h504, {14'h0, r[1:0], 16'h0});
      rc(12'h504, {14'h0, r[1:0], 16'h0});
    end
    wr(12'h500, 32'h1);
    wr(12'h000, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    chk("busy", {31'h0, busy}, 32'h0);
  endtask

  task automatic s_keystream();
    wr(12'h500, 32'h2);
    wr(12'h514, 32'h200);
    wr(12'h304, 32'h1);
    c0 = wr_cnt;
    wr(12'h000, 32'h1);
    idle(600);
    chk("ks writes", 32'(wr_cnt - c0), 32'd43);
    rc(12'h100, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(12'h100, 32'h0);
    rc(12'h100, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(12'h504, 32'h01000001);
    wr(12'h518, 32'h20);
    c0 = wr_cnt;
    wr(12'h000, 32'h1);
    idle(600);
    chk("ext writes", 32'(wr_cnt - c0), 32'd48);
    wr(12'h100, 32'h0);
  endtask

  task automatic s_task_a();
    wr(12'h200, 32'h1);
    wr(12'h504, 32'h00020001);
    wr(12'h50c, 32'h300);
    wr(12'h510, 32'h380);
    c0 = wr_cnt;
    wr(12'h000, 32'h1);
    idle(1500);
    chk("link writes", 32'(wr_cnt - c0), 32'd49);
    rc(12'h104, 32'h1);
    wr(12'h200, 32'h0);
    wr(12'h104, 32'h0);
    wr(12'h504, 32'h00020000);
    c0 = wr_cnt;
    wr(12'h004, 32'h1);
    // Slow rate written mid-run must not reach this packet
    wr(12'h504, 32'h1);
    idle(1500);
    chk("enc writes", 32'(wr_cnt - c0), 32'd10);
    rc(12'h104, 32'h1);
    wr(12'h104, 32'h0);
    wr(12'h51c, 32'h2);
    wr(12'h004, 32'h1);
    wr(12'h00c, 32'h1);
    idle(1500);
    rc(12'h104, 32'h1);
    wr(12'h104, 32'h0);
  endtask

  task automatic s_stop_slow();
    wr(12'h004, 32'h1);
    repeat (20) @(posedge clk);
    ce <= 1'b0;
    // A stop written while frozen is lost, so the run goes on
    wr(12'h008, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("frozen busy", {31'h0, busy}, 32'h1);
    @(posedge clk);
    ce <= 1'b1;
    wr(12'h008, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("busy", {31'h0, busy}, 32'h0);
    rc(12'h104, 32'h0);
    lat <= 4'h8;
    wr(12'h000, 32'h1);
    idle(2000);
    rc(12'h108, 32'h1);
    wr(12'h108, 32'h0);
    rc(12'h108, 32'h0);
    // Two slow RAM beats outlast one byte time
    wr(12'h504, 32'h00020001);
    wr(12'h004, 32'h1);
    idle(2000);
    rc(12'h108, 32'h1);
    wr(12'h100, 32'h0);
    rc(12'h100, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lat = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_regs();
    s_keystream();
    s_task_a();
    s_stop_slow();
    test_done();
  end
endmodule
